// *** inc/lwsr_pkg.sv ***
package lwsr_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT  = 16;
  localparam int unsigned FLAG_COUNT = 8;

  // pins 1 and 2 have no pad
  localparam logic [15:0] PIN_PRESENT_MASK  = 16'hFFF9;
  // flags 0..2: timer, comparator 0, comparator 1
  localparam logic [7:0]  FLAG_PRESENT_MASK = 8'h07;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_EN    = 8'h00;
  localparam logic [7:0] ADDR_FLAG_EN   = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h18;

  // ctrl bit positions
  localparam int unsigned CTRL_NMI_PIN_EN   = 0;
  localparam int unsigned CTRL_RESET_PIN_EN = 1;
  localparam int unsigned CTRL_IN_STOP      = 2;

  // event bit positions in irq status
  localparam int unsigned EV_PIN_WAKE   = 0;
  localparam int unsigned EV_FLAG_WAKE  = 1;
  localparam int unsigned EV_NMI_WAKE   = 2;
  localparam int unsigned EV_RESET_WAKE = 3;
  localparam int unsigned EV_COUNT      = 4;

  localparam logic [15:0] PIN_EN_RESET  = 16'h0000;
  localparam logic [7:0]  FLAG_EN_RESET = 8'h00;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } lwsr_req_t;

  typedef struct packed {
    logic wakeReq;
    logic nmiReq;
    logic pinWake;
    logic flagWake;
  } lwsr_wake_t;

endpackage : lwsr_pkg

// *** src/lwsr_wake_router.sv ***
// How it works
// - sixteen pin wake inputs, indices 1 and 2 unconnected and ignored
// - eight module flag inputs: timer, comparator 0, comparator 1, rest reserved
// - a module flag wakes only while its module wake enable bit is set
// - module flags are never cleared here; the peripheral clears them
// - enabled reset pin asserted always wakes the device; enabled nmi pin wakes unless the nmi disable option is set
// - nmi enabled at stop entry: nmi pin raises nmi while still in stop and on exit
// - nonvolatile nmi disable option suppresses any nmi from the pin
`timescale 1ns/1ps
`default_nettype none

module lwsr_wake_router (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // wake sources
  input  wire logic [15:0] wakePinInput,
  input  wire logic [7:0]  moduleWakeFlagInput,
  input  wire logic        nmiPinAsserted,
  input  wire logic        resetPinAsserted,
  input  wire logic        nonmaskablePinDisable,
  // towards the mode controller
  output logic             wakeRequest,
  output logic             nmiRequest,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]                  pinEnable_reg;
  logic [7:0]                   moduleWakeEnable_reg;
  logic [2:0]                   ctrl_reg;
  logic                         nmiArmed_reg;
  logic [lwsr_pkg::EV_COUNT-1:0] irqStat_reg;
  logic [lwsr_pkg::EV_COUNT-1:0] irqEn_reg;
  logic                         lowStop_reg;
  lwsr_pkg::lwsr_req_t          req_reg;

  // ----------------------------------------------------------------
  // wake evaluation
  // ----------------------------------------------------------------
  wire logic [15:0] pinLive;
  wire logic [7:0]  flagLive;
  wire logic        nmiPinEn;
  wire logic        resetPinEn;
  wire logic        nmiUsable;
  wire logic        inStop;
  wire logic        nmiWake;
  wire logic        resetWake;
  wire lwsr_pkg::lwsr_wake_t wake;

  assign pinLive    = wakePinInput & pinEnable_reg & lwsr_pkg::PIN_PRESENT_MASK;
  // flags are only observed, never written back
  assign flagLive   = moduleWakeFlagInput & moduleWakeEnable_reg
                      & lwsr_pkg::FLAG_PRESENT_MASK;
  assign nmiPinEn   = ctrl_reg[lwsr_pkg::CTRL_NMI_PIN_EN];
  assign resetPinEn = ctrl_reg[lwsr_pkg::CTRL_RESET_PIN_EN];
  assign inStop     = ctrl_reg[lwsr_pkg::CTRL_IN_STOP];
  assign nmiUsable  = nmiPinEn & ~nonmaskablePinDisable;

  assign wake.pinWake  = |pinLive;
  assign wake.flagWake = |flagLive;
  assign nmiWake       = nmiUsable & nmiPinAsserted;
  assign resetWake     = resetPinEn & resetPinAsserted;
  assign wake.wakeReq  = wake.pinWake | wake.flagWake | nmiWake | resetWake;
  assign wake.nmiReq   = nmiArmed_reg & nmiPinAsserted & ~nonmaskablePinDisable;

  // ----------------------------------------------------------------
  // stop-entry capture
  // ----------------------------------------------------------------
  wire logic stopEntry;
  wire logic stopExit;
  assign stopEntry = inStop & ~lowStop_reg;
  assign stopExit  = ~inStop & lowStop_reg;

  logic nmiArmed_next;
  always_comb begin
    nmiArmed_next = nmiArmed_reg;
    if (stopEntry) begin
      nmiArmed_next = nmiUsable;
    end else if (!inStop && !(nmiArmed_reg && nmiPinAsserted)) begin
      nmiArmed_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic addrPhase;
  wire logic wrPinEn;
  wire logic wrFlagEn;
  wire logic wrCtrl;
  wire logic wrIrqClr;
  wire logic wrIrqEn;
  wire logic dataWr;

  assign addrPhase = hsel & hready & (htrans == lwsr_pkg::HTRANS_NONSEQ);
  assign dataWr    = req_reg.sel & req_reg.write;
  // data-phase write strobe of one register word
  function automatic logic wordWrite(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    wordWrite = strobe & (addr == target);
  endfunction : wordWrite

  assign wrPinEn   = wordWrite(dataWr, req_reg.addr, lwsr_pkg::ADDR_PIN_EN);
  assign wrFlagEn  = wordWrite(dataWr, req_reg.addr, lwsr_pkg::ADDR_FLAG_EN);
  assign wrCtrl    = wordWrite(dataWr, req_reg.addr, lwsr_pkg::ADDR_CTRL);
  assign wrIrqClr  = wordWrite(dataWr, req_reg.addr, lwsr_pkg::ADDR_IRQ_CLR);
  assign wrIrqEn   = wordWrite(dataWr, req_reg.addr, lwsr_pkg::ADDR_IRQ_EN);

  wire logic [31:0] statusWord;
  assign statusWord = {26'h0000000, wake.nmiReq, wake.wakeReq, nmiArmed_reg,
                       wake.flagWake, wake.pinWake, inStop};

  logic [31:0] readMux;
  always_comb begin
    case (haddr)
      lwsr_pkg::ADDR_PIN_EN:   readMux = {16'h0000, pinEnable_reg};
      lwsr_pkg::ADDR_FLAG_EN:  readMux = {24'h000000, moduleWakeEnable_reg};
      lwsr_pkg::ADDR_CTRL:     readMux = {29'h0000000, ctrl_reg};
      lwsr_pkg::ADDR_STATUS:   readMux = statusWord;
      lwsr_pkg::ADDR_IRQ_STAT: readMux = {28'h0000000, irqStat_reg};
      lwsr_pkg::ADDR_IRQ_EN:   readMux = {28'h0000000, irqEn_reg};
      default:                 readMux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  wire logic [lwsr_pkg::EV_COUNT-1:0] events;
  assign events = {resetWake,
                   nmiWake,
                   wake.flagWake,
                   wake.pinWake};

  logic [lwsr_pkg::EV_COUNT-1:0] irqStat_next;
  always_comb begin
    irqStat_next = irqStat_reg;
    if (wrIrqClr) begin
      irqStat_next = irqStat_reg & ~hwdata[lwsr_pkg::EV_COUNT-1:0];
    end
    // set wins over clear
    irqStat_next = irqStat_next | events;
  end

  // ----------------------------------------------------------------
  // bus request capture
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg.sel   <= addrPhase;
      req_reg.write <= hwrite;
      req_reg.addr  <= haddr;
    end
  end

  // ----------------------------------------------------------------
  // read data, taken at the address phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // bus response: no wait states, always okay
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // pin wake enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinEnable_reg <= lwsr_pkg::PIN_EN_RESET;
    end else if (wrPinEn) begin
      pinEnable_reg <= hwdata[15:0] & lwsr_pkg::PIN_PRESENT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // module wake enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      moduleWakeEnable_reg <= lwsr_pkg::FLAG_EN_RESET;
    end else if (wrFlagEn) begin
      moduleWakeEnable_reg <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= lwsr_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= hwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqEn_reg <= '0;
    end else if (wrIrqEn) begin
      irqEn_reg <= hwdata[lwsr_pkg::EV_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, sticky
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  // ----------------------------------------------------------------
  // stop mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lowStop_reg <= 1'h0;
    end else begin
      lowStop_reg <= inStop;
    end
  end

  // ----------------------------------------------------------------
  // nmi arming at stop entry
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nmiArmed_reg <= 1'h0;
    end else begin
      nmiArmed_reg <= nmiArmed_next;
    end
  end

  // ----------------------------------------------------------------
  // requests to the mode controller
  // ----------------------------------------------------------------
  wire logic nmiOnExit;
  assign nmiOnExit = stopExit & nmiArmed_reg & nmiPinAsserted
                     & ~nonmaskablePinDisable;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wakeRequest <= 1'h0;
      nmiRequest  <= 1'h0;
    end else begin
      wakeRequest <= wake.wakeReq;
      nmiRequest  <= wake.nmiReq | nmiOnExit;
    end
  end

  // ----------------------------------------------------------------
  // interrupt line
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irqStat_next & irqEn_reg);
    end
  end

endmodule : lwsr_wake_router

`default_nettype wire

// *** sim/lwsr_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module lwsr_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [15:0] wakePinInput,
  input wire logic [7:0]  moduleWakeFlagInput,
  input wire logic        nmiPinAsserted,
  input wire logic        resetPinAsserted,
  input wire logic        nonmaskablePinDisable,
  input wire logic        wakeRequest,
  input wire logic        nmiRequest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic        wr_reg;
  logic [7:0]  adr_reg;
  logic [15:0] pin_reg;
  logic [7:0]  flg_reg;
  logic [2:0]  ctl_reg;
  wire         pinHit = |(wakePinInput & pin_reg & lwsr_pkg::PIN_PRESENT_MASK);
  wire         flgHit = |(moduleWakeFlagInput & flg_reg & lwsr_pkg::FLAG_PRESENT_MASK);
  wire         rstHit = resetPinAsserted && ctl_reg[1];
  wire         nmiHit = nmiPinAsserted && ctl_reg[0];
  // shadow of the enable registers
  always_ff @(posedge core_clk) begin
    adr_reg <= haddr;
    if (!rst_n) begin
      wr_reg <= 1'h0;
      {pin_reg, flg_reg, ctl_reg} <= 27'h0;
    end else begin
      wr_reg <= hsel && hready && hwrite && htrans == lwsr_pkg::HTRANS_NONSEQ;
      if (wr_reg && adr_reg == lwsr_pkg::ADDR_PIN_EN) pin_reg <= hwdata[15:0];
      if (wr_reg && adr_reg == lwsr_pkg::ADDR_FLAG_EN) flg_reg <= hwdata[7:0];
      if (wr_reg && adr_reg == lwsr_pkg::ADDR_CTRL) ctl_reg <= hwdata[2:0];
    end
  end
  property p_pin; pinHit |=> wakeRequest; endproperty
  a_pin: assert property (p_pin) else $error("pin wake lost");
  property p_flag; flgHit |=> wakeRequest; endproperty
  a_flag: assert property (p_flag) else $error("flag wake lost");
  property p_rstpin; rstHit |=> wakeRequest; endproperty
  a_rstpin: assert property (p_rstpin) else $error("reset pin wake lost");
  property p_nmipin; nmiHit && !nonmaskablePinDisable |=> wakeRequest; endproperty
  a_nmipin: assert property (p_nmipin) else $error("nmi pin wake lost");
  property p_only; !(pinHit || flgHit || rstHit || nmiHit) |=> !wakeRequest; endproperty
  a_only: assert property (p_only) else $error("wake without cause");
  property p_nmicause; nmiRequest |-> $past(nmiPinAsserted); endproperty
  a_nmicause: assert property (p_nmicause) else $error("nmi without pin");
  property p_nmiquiet; !nmiPinAsserted [*2] |-> !nmiRequest; endproperty
  a_nmiquiet: assert property (p_nmiquiet) else $error("nmi stuck");
  property p_stand; flgHit [*2] |=> wakeRequest && $past(wakeRequest); endproperty
  a_stand: assert property (p_stand) else $error("flag wake dropped");
  property p_nmidis; nonmaskablePinDisable |=> !nmiRequest; endproperty
  a_nmidis: assert property (p_nmidis) else $error("nmi while disabled");
  property p_nmiarm;
    $rose(ctl_reg[2]) && ctl_reg[0] && !nonmaskablePinDisable ##1
      ctl_reg[2] && nmiPinAsserted && !nonmaskablePinDisable |=> nmiRequest;
  endproperty
  a_nmiarm: assert property (p_nmiarm) else $error("armed nmi not raised");
endmodule : lwsr_chk
bind lwsr_wake_router lwsr_chk u_chk (.core_clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .wakePinInput, .moduleWakeFlagInput, .nmiPinAsserted,
  .resetPinAsserted, .nonmaskablePinDisable, .wakeRequest, .nmiRequest);
`default_nettype wire

// *** sim/lwsr_periph_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lwsr_periph_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] pEn,
  input  wire logic [2:0] evt,
  input  wire logic [2:0] clr,
  input  wire logic [4:0] rsv,
  output logic      [7:0] flags
);
  logic [2:0] flag_reg;
  // flag held until its own peripheral clears it
  always_ff @(posedge core_clk) begin
    if (!rst_n) flag_reg <= 3'h0;
    else flag_reg <= (flag_reg & ~clr) | (evt & pEn);
  end
  assign flags = {rsv, flag_reg};
endmodule : lwsr_periph_model
`default_nettype wire

// *** sim/test_low_leakage_wake_source_routing.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_low_leakage_wake_source_routing;
  logic        core_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        nmiPin = 1'h0, rstPin = 1'h0, nmiDis = 1'h0, rdPh = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] pins = 16'h0;
  logic [2:0]  pEn = 3'h0, evt = 3'h0, clr = 3'h0;
  logic [4:0]  rsv = 5'h0;
  logic        hreadyout, hresp, wakeRequest, nmiRequest, irq;
  logic [31:0] hrdata;
  logic [7:0]  flags;
  logic [34:0] q[$];
  int          err_total = 0, n_compared = 0, idx;
  always #2.5 core_clk = ~core_clk;
  lwsr_wake_router DUT (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(lwsr_pkg::HSIZE_WORD), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .wakePinInput(pins), .moduleWakeFlagInput(flags), .nmiPinAsserted(nmiPin),
    .resetPinAsserted(rstPin), .nonmaskablePinDisable(nmiDis), .wakeRequest,
    .nmiRequest, .irq);
  lwsr_periph_model u_per (.core_clk, .rst_n, .pEn, .evt, .clr, .rsv, .flags);
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    hsel <= 1'h1;
    htrans <= lwsr_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    repeat (2) begin
      n = 0;
      do @(posedge core_clk); while (hreadyout !== 1'h1 && ++n < 50);
      if (n == 50) begin
        $display("CHECK FAILED %0t bus hang", $time);
        err_total++;
        conclude();
      end
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
    end
    n_compared++;
    if (hresp !== 1'h0) begin
      err_total++;
      $display("CHECK FAILED %0t error response", $time);
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [34:0] e);
    q.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask : rd
  // unmapped read: data 0, ports irq, nmi, wake
  task automatic probe(input logic [2:0] e);
    repeat (3) @(posedge core_clk);
    rd(8'h1C, {e, 32'h0});
  endtask : probe
  always @(posedge core_clk) begin
    if (rdPh) begin
      n_compared++;
      if ({irq, nmiRequest, wakeRequest, hrdata} !== q[0]) begin
        err_total++;
        $display("CHECK FAILED %0t got %h", $time, {irq, nmiRequest, wakeRequest, hrdata});
      end
      void'(q.pop_front());
    end
    rdPh <= hsel && !hwrite && htrans == lwsr_pkg::HTRANS_NONSEQ;
  end
  initial begin
    void'($urandom(32'hFC1A73A5));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(lwsr_pkg::ADDR_PIN_EN, 35'h0);
    wr(lwsr_pkg::ADDR_PIN_EN, 32'hFFFFFFFF);
    rd(lwsr_pkg::ADDR_PIN_EN, 35'h0FFF9);
    pins <= 16'h0006;
    probe(3'h0);
    do idx = $urandom_range(15); while (!lwsr_pkg::PIN_PRESENT_MASK[idx]);
    pins <= 16'h0001 << idx;
    probe(3'h1);
    rd(lwsr_pkg::ADDR_IRQ_STAT, {3'h1, 32'h1});
    pins <= 16'h0;
    wr(lwsr_pkg::ADDR_IRQ_CLR, 32'hF);
    wr(lwsr_pkg::ADDR_IRQ_EN, 32'hF);
    $display("pin test done");
    rsv <= 5'h1F;
    pEn <= 3'h5;
    evt <= 3'h3;
    @(posedge core_clk);
    evt <= 3'h0;
    probe(3'h0);
    wr(lwsr_pkg::ADDR_FLAG_EN, 32'h2);
    probe(3'h0);
    wr(lwsr_pkg::ADDR_FLAG_EN, 32'hFF);
    probe(3'h5);
    wr(lwsr_pkg::ADDR_IRQ_CLR, 32'hF);
    probe(3'h5);
    clr <= 3'h1;
    @(posedge core_clk);
    clr <= 3'h0;
    probe(3'h4);
    wr(lwsr_pkg::ADDR_IRQ_CLR, 32'hF);
    $display("flag test done");
    rstPin <= 1'h1;
    probe(3'h0);
    wr(lwsr_pkg::ADDR_CTRL, 32'h2);
    probe(3'h5);
    rstPin <= 1'h0;
    wr(lwsr_pkg::ADDR_IRQ_EN, 32'h0);
    wr(lwsr_pkg::ADDR_CTRL, 32'h1);
    wr(lwsr_pkg::ADDR_CTRL, 32'h5);
    nmiPin <= 1'h1;
    probe(3'h3);
    wr(lwsr_pkg::ADDR_CTRL, 32'h1);
    probe(3'h3);
    nmiPin <= 1'h0;
    wr(lwsr_pkg::ADDR_CTRL, 32'h1);
    nmiDis <= 1'h1;
    pins <= 16'h0001;
    wr(lwsr_pkg::ADDR_CTRL, 32'h5);
    nmiPin <= 1'h1;
    probe(3'h1);
    $display("nmi test done");
    @(posedge core_clk);
    conclude();
  end
endmodule : test_low_leakage_wake_source_routing
`default_nettype wire
